// *** hhd_cfg_regs.v ***
// hardware and dma configuration registers with pin polarity logic
`timescale 1ns/100ps
`include "hhd_regs.vh"

module hhd_cfg_regs #(
  parameter SRC_W = 16
) (
  // clock and reset
  input  wire             core_clk_in,
  input  wire             reset_in,
  // host command port
  input  wire             cmd_valid_in,
  input  wire [7:0]       cmd_code_in,
  input  wire [15:0]      cmd_wdata_in,
  output reg  [15:0]      cmd_rdata_out,
  output reg              cmd_rvalid_out,
  // dma pins and strobes
  input  wire             dma_ack_pin_n_in,
  input  wire             dma_rd_strobe_in,
  input  wire             dma_wr_strobe_in,
  input  wire             end_of_transfer_input_in,
  output reg              dma_request_pin_out,
  output reg              dma_access_out,
  // transfer counter side
  input  wire [15:0]      byte_count_in,
  input  wire             count_done_in,
  // interrupt sources
  input  wire [SRC_W-1:0] irq_pending_in,
  input  wire [SRC_W-1:0] host_irq_enable_in,
  output reg              irq_pin_out,
  // configuration fan-out
  output reg              pulldown_internal_out,
  output reg              keep_clock_in_suspend_out,
  output reg              overcurrent_analog_select_out,
  output reg              transfer_active_out,
  output reg  [1:0]       burst_length_out,
  output reg              byte_count_select_out,
  output reg              buffer_list_select_out,
  output reg              transfer_direction_out
);

  // stored registers, their next values and the burst state
  reg  [15:0]      hw_cfg_q;
  reg  [15:0]      hw_cfg_d;
  reg  [15:0]      dma_cfg_q;
  reg  [15:0]      dma_cfg_d;
  reg  [3:0]       beat_cnt_q;
  reg  [3:0]       beat_cnt_d;
  reg              gap_q;
  reg  [SRC_W-1:0] irq_seen_q;
  reg              gap_d;
  reg  [3:0]       beats;
  reg  [15:0]      rdata_d;
  reg              req_pin_d;
  reg              irq_pin_d;

  // decode, qualification and interrupt combine

  wire             is_write;
  wire [6:0]       reg_idx;
  wire             hit_hw;
  wire             hit_dma;
  wire             eot_active;
  wire             ack_active;
  wire             access;
  wire             transfer_end;
  wire             count_ok;
  wire             req_raw;
  wire             last_beat;
  wire             wr_hw;
  wire             wr_dma;
  wire             rd_any;
  wire [SRC_W-1:0] irq_live;
  wire             irq_level;
  wire             irq_new;
  reg              irq_assert;

  assign is_write = cmd_code_in[`HHD_WR_FLAG_BIT];
  assign reg_idx  = cmd_code_in[6:0];
  assign hit_hw   = cmd_valid_in && (reg_idx == `HHD_HW_CFG_IDX);
  assign hit_dma  = cmd_valid_in && (reg_idx == `HHD_DMA_CFG_IDX);

  // unknown indices fall through and leave every register alone
  assign wr_hw    = hit_hw && is_write;
  assign wr_dma   = hit_dma && is_write;
  assign rd_any   = (hit_hw || hit_dma) && !is_write;

  // end-of-transfer input polarity follows its stored bit
  assign eot_active = end_of_transfer_input_in ~^
                      hw_cfg_q[`HHD_HW_EOTPOL_BIT];
  // acknowledge is always taken active low; the high setting is reserved
  assign ack_active = ~dma_ack_pin_n_in;

  // acknowledge only counts with a strobe in normal mode
  assign access = ack_active &&
                  (dma_rd_strobe_in || dma_wr_strobe_in) &&
                  !hw_cfg_q[`HHD_HW_ACKMODE_BIT] &&
                  dma_cfg_q[`HHD_DMA_EN_BIT];

  // without the counter only the external end marks completion
  assign transfer_end = dma_cfg_q[`HHD_DMA_CNTSEL_BIT] ?
                        count_done_in :
                        eot_active;

  assign count_ok = !dma_cfg_q[`HHD_DMA_CNTSEL_BIT] ||
                    (byte_count_in != 16'h0000);

  // reserved burst code 11 falls back to single beats
  always @* begin
    case (dma_cfg_q[`HHD_DMA_BURST_HI:`HHD_DMA_BURST_LO])
      `HHD_BURST_4: begin
        beats = `HHD_BEATS_4;
      end
      `HHD_BURST_8: begin
        beats = `HHD_BEATS_8;
      end
      default: begin
        beats = `HHD_BEATS_1;
      end
    endcase
  end

  assign last_beat = (beat_cnt_q + 4'h1) >= beats;

  // one idle cycle between bursts lets the dma controller rearbitrate
  assign req_raw = dma_cfg_q[`HHD_DMA_EN_BIT] && count_ok &&
                   !gap_q && !transfer_end;

  // interrupt combine
  assign irq_live   = irq_pending_in & host_irq_enable_in;
  assign irq_level  = hw_cfg_q[`HHD_HW_IRQEN_BIT] &&
                      (|irq_live);
  assign irq_new    = hw_cfg_q[`HHD_HW_IRQEN_BIT] &&
                      (|(irq_live & ~irq_seen_q));

  // trigger style picks the level view or the fresh-event view
  always @* begin
    case (hw_cfg_q[`HHD_HW_IRQTRIG_BIT])
      1'b1: begin
        irq_assert = irq_new;
      end
      default: begin
        irq_assert = irq_level;
      end
    endcase
  end

  // next hardware configuration
  always @* begin
    hw_cfg_d = hw_cfg_q;
    if (hit_hw && is_write) begin
      hw_cfg_d = cmd_wdata_in & `HHD_HW_CFG_MASK;
    end
    // width field cannot be altered by software
    hw_cfg_d[`HHD_HW_WIDTH_HI:`HHD_HW_WIDTH_LO] = `HHD_WIDTH_16;
  end

  // next dma configuration
  always @* begin
    dma_cfg_d = dma_cfg_q;
    if (hit_dma && is_write) begin
      dma_cfg_d = cmd_wdata_in & `HHD_DMA_CFG_MASK;
    end
    // completion beats a same-cycle write so a finished job never restarts
    if (dma_cfg_q[`HHD_DMA_EN_BIT] && transfer_end) begin
      dma_cfg_d[`HHD_DMA_EN_BIT] = 1'b0;
    end
  end

  // burst beat counter
  always @* begin
    beat_cnt_d = beat_cnt_q;
    if (!dma_cfg_q[`HHD_DMA_EN_BIT] || gap_q) begin
      beat_cnt_d = 4'h0;
    end else if (access) begin
      if (last_beat) begin
        beat_cnt_d = 4'h0;
      end else begin
        beat_cnt_d = beat_cnt_q + 4'h1;
      end
    end
  end

  // the cycle after a burst's last beat is the rearbitration gap
  always @* begin
    gap_d = 1'b0;
    if (access && dma_cfg_q[`HHD_DMA_EN_BIT] && last_beat) begin
      gap_d = 1'b1;
    end
  end

  // register state
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      hw_cfg_q   <= `HHD_HW_CFG_RST;
      dma_cfg_q  <= `HHD_DMA_CFG_RST;
      beat_cnt_q <= 4'h0;
      gap_q      <= 1'b0;
      irq_seen_q <= {SRC_W{1'b0}};
    end else begin
      hw_cfg_q   <= hw_cfg_d;
      dma_cfg_q  <= dma_cfg_d;
      beat_cnt_q <= beat_cnt_d;
      gap_q      <= gap_d;
      // only pending enabled bits are remembered, so a re-raise pulses again
      irq_seen_q <= irq_live;
    end
  end

  // read mux shows stored contents, not a same-cycle write
  always @* begin
    rdata_d = 16'h0000;
    if (hit_dma) begin
      rdata_d = dma_cfg_q;
    end else if (hit_hw) begin
      rdata_d = hw_cfg_q;
    end
  end

  // read port
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      cmd_rdata_out  <= 16'h0000;
      cmd_rvalid_out <= 1'b0;
    end else begin
      cmd_rvalid_out <= rd_any;
      if (rd_any) begin
        cmd_rdata_out <= rdata_d;
      end
    end
  end

  // pin levels before the output flops
  always @* begin
    req_pin_d = req_raw ~^ hw_cfg_q[`HHD_HW_REQPOL_BIT];
    irq_pin_d = irq_assert ~^ hw_cfg_q[`HHD_HW_IRQPOL_BIT];
  end

  // request pin; held high in reset, settles after the first edge
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      dma_request_pin_out <= 1'b1;
    end else begin
      dma_request_pin_out <= req_pin_d;
    end
  end

  // one access pulse per qualified acknowledge and strobe
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      dma_access_out <= 1'b0;
    end else begin
      dma_access_out <= access;
    end
  end

  // disabled pin rests at its inactive level
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      irq_pin_out <= 1'b1;
    end else begin
      irq_pin_out <= irq_pin_d;
    end
  end

  // hardware configuration fan-out follows the next value
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      pulldown_internal_out         <= 1'b0;
      keep_clock_in_suspend_out     <= 1'b0;
      overcurrent_analog_select_out <= 1'b0;
    end else begin
      pulldown_internal_out         <= hw_cfg_d[`HHD_HW_PULLDN_BIT];
      keep_clock_in_suspend_out     <= hw_cfg_d[`HHD_HW_KEEPCLK_BIT];
      overcurrent_analog_select_out <= hw_cfg_d[`HHD_HW_OCANA_BIT];
    end
  end

  // dma configuration fan-out, cleared enable included
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      transfer_active_out           <= 1'b0;
      burst_length_out              <= `HHD_BURST_1;
      byte_count_select_out         <= 1'b0;
      buffer_list_select_out        <= 1'b0;
      transfer_direction_out        <= 1'b0;
    end else begin
      transfer_active_out           <= dma_cfg_d[`HHD_DMA_EN_BIT];
      burst_length_out              <= dma_cfg_d[6:5];
      byte_count_select_out         <= dma_cfg_d[`HHD_DMA_CNTSEL_BIT];
      buffer_list_select_out        <= dma_cfg_d[`HHD_DMA_BUFSEL_BIT];
      transfer_direction_out        <= dma_cfg_d[`HHD_DMA_DIR_BIT];
    end
  end

endmodule // hhd_cfg_regs

// *** hhd_regs.vh ***
// register codes, field positions and reset values of the config bank
`ifndef HHD_REGS_VH
`define HHD_REGS_VH
`define HHD_HW_CFG_IDX      7'h20
`define HHD_DMA_CFG_IDX     7'h21
`define HHD_WR_FLAG_BIT     7
`define HHD_HW_PULLDN_BIT   12
`define HHD_HW_KEEPCLK_BIT  11
`define HHD_HW_OCANA_BIT    10
`define HHD_HW_ACKMODE_BIT  8
`define HHD_HW_EOTPOL_BIT   7
`define HHD_HW_ACKPOL_BIT   6
`define HHD_HW_REQPOL_BIT   5
`define HHD_HW_WIDTH_HI     4
`define HHD_HW_WIDTH_LO     3
`define HHD_HW_IRQPOL_BIT   2
`define HHD_HW_IRQTRIG_BIT  1
`define HHD_HW_IRQEN_BIT    0
`define HHD_WIDTH_16        2'h1
`define HHD_HW_CFG_RST      16'h0028
`define HHD_HW_CFG_MASK     16'h1DE7
`define HHD_DMA_BURST_HI    6
`define HHD_DMA_BURST_LO    5
`define HHD_DMA_EN_BIT      4
`define HHD_DMA_CNTSEL_BIT  2
`define HHD_DMA_BUFSEL_BIT  1
`define HHD_DMA_DIR_BIT     0
`define HHD_DMA_CFG_RST     16'h0000
`define HHD_DMA_CFG_MASK    16'h0077
`define HHD_BURST_1         2'h0
`define HHD_BURST_4         2'h1
`define HHD_BURST_8         2'h2
`define HHD_BEATS_1         4'h1
`define HHD_BEATS_4         4'h4
`define HHD_BEATS_8         4'h8
`endif

// *** hhd_cfg_regs_properties.sv ***
// timing checker for the configuration bank ports
`timescale 1ns/100ps
module hhd_cfg_props #(parameter SRC_W = 16) (
  input wire             core_clk_in, reset_in, cmd_valid_in, cmd_rvalid_out, count_done_in,
  input wire [7:0]       cmd_code_in,
  input wire [15:0]      cmd_wdata_in, cmd_rdata_out, byte_count_in,
  input wire             dma_ack_pin_n_in, dma_rd_strobe_in, dma_wr_strobe_in,
  input wire             end_of_transfer_input_in, dma_request_pin_out, dma_access_out,
  input wire             irq_pin_out, pulldown_internal_out, keep_clock_in_suspend_out,
  input wire             overcurrent_analog_select_out, byte_count_select_out,
  input wire             buffer_list_select_out, transfer_direction_out,
  input wire [1:0]       burst_length_out,
  input wire [SRC_W-1:0] irq_pending_in, host_irq_enable_in
);
  // shadow copies let the checker know polarities without seeing the body
  reg  [15:0] hw_q, dma_q;
  wire        pend = |(irq_pending_in & host_irq_enable_in);
  wire        fin  = dma_q[2] ? count_done_in : end_of_transfer_input_in == hw_q[7];
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      hw_q  <= 16'h0028;
      dma_q <= 16'h0000;
    end else begin
      if (cmd_valid_in && cmd_code_in == 8'hA0) hw_q <= cmd_wdata_in & 16'h1DE7 | 16'h0008;
      if (cmd_valid_in && cmd_code_in == 8'hA1) dma_q <= cmd_wdata_in & 16'h0077;
      if (fin && dma_q[4]) dma_q[4] <= 1'b0;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_rd;
    cmd_valid_in && cmd_code_in[7:1] == 7'h10;
  endsequence
  a_read_answer: assert property (s_rd |=> cmd_rvalid_out)
    else $error("read not answered");
  a_read_data: assert property (cmd_rvalid_out |-> $past(cmd_valid_in && cmd_code_in[7:1] == 7'h10)
    && cmd_rdata_out == ($past(cmd_code_in[0]) ? $past(dma_q) : $past(hw_q)))
    else $error("read data wrong");
  a_irq_off: assert property (!hw_q[0] |=> irq_pin_out == !$past(hw_q[2]))
    else $error("irq pin active while disabled");
  a_irq_level: assert property (hw_q[0] && !hw_q[1] && pend |=> irq_pin_out == $past(hw_q[2]))
    else $error("level irq not asserted");
  a_irq_edge_once: assert property (hw_q[1] && $stable(hw_q) && $stable(irq_pending_in
    & host_irq_enable_in) |=> irq_pin_out == !$past(hw_q[2]))
    else $error("edge irq held");
  a_req_idle: assert property (!dma_q[4] || dma_q[2] && byte_count_in == 16'h0000
    |=> dma_request_pin_out == !$past(hw_q[5]))
    else $error("request raised wrongly");
  a_access_qual: assert property (dma_access_out |-> $past(!dma_ack_pin_n_in && !hw_q[8]
    && (dma_rd_strobe_in || dma_wr_strobe_in) && dma_q[4]))
    else $error("unqualified access");
  a_dma_fanout: assert property (cmd_valid_in && cmd_code_in == 8'hA1 |=> {burst_length_out,
    byte_count_select_out, buffer_list_select_out, transfer_direction_out}
    == {$past(cmd_wdata_in[6:5]), $past(cmd_wdata_in[2:0])})
    else $error("dma config outputs wrong");
  a_hw_fanout: assert property (cmd_valid_in && cmd_code_in == 8'hA0 |=> {pulldown_internal_out,
    keep_clock_in_suspend_out, overcurrent_analog_select_out}
    == $past(cmd_wdata_in[12:10]))
    else $error("hw config outputs wrong");
endmodule // hhd_cfg_props
bind hhd_cfg_regs hhd_cfg_props #(.SRC_W(SRC_W)) u_props (.*);

// *** hhd_dma_host.sv ***
// host-side dma controller answering the request pin
`timescale 1ns/100ps
module hhd_dma_host (
  input  wire clk_in, req_pin_in, req_high_in, run_in, slow_in, dir_wr_in, eot_in, eot_high_in,
  output reg  ack_n_out = 1'b1,
  output reg  rd_out = 1'b0,
  output reg  wr_out = 1'b0,
  output wire eot_out
);
  reg  ph = 1'b0;
  wire go = run_in && (!slow_in || ph) && req_pin_in == req_high_in;
  // end of transfer only on command, otherwise its idle level
  assign eot_out = eot_in ? eot_high_in : !eot_high_in;
  always @(posedge clk_in) begin
    ph        <= !ph;
    ack_n_out <= !go;
    rd_out    <= go && !dir_wr_in;
    wr_out    <= go && dir_wr_in;
  end
endmodule // hhd_dma_host

// *** tb_top.sv ***
// self-checking bench for the configuration bank
`timescale 1ns/100ps
module tb_top;
  reg         core_clk_in = 0, reset_in = 1, cmd_valid_in = 0, count_done_in = 0;
  reg  [7:0]  cmd_code_in = 8'h00;
  reg  [15:0] cmd_wdata_in = 16'h0000, byte_count_in = 16'h0000;
  reg  [15:0] irq_pending_in = 16'h0000, host_irq_enable_in = 16'h0000;
  reg         run = 0, slow = 0, end_of_transfer_input = 0;
  wire [15:0] cmd_rdata_out;
  wire [1:0]  burst_length_out;
  wire        cmd_rvalid_out, dma_ack_pin_n_in, dma_rd_strobe_in, dma_wr_strobe_in;
  wire        end_of_transfer_input_in, dma_request_pin_out, dma_access_out, irq_pin_out;
  wire        pulldown_internal_out, keep_clock_in_suspend_out, overcurrent_analog_select_out;
  wire        transfer_active_out, byte_count_select_out, buffer_list_select_out;
  wire        transfer_direction_out;
  integer     bad_count = 0, samples_checked = 0, cycles = 0, hits, b;
  always #4 core_clk_in = !core_clk_in;
  hhd_cfg_regs uut (.*);
  hhd_dma_host host (.clk_in(core_clk_in), .req_pin_in(dma_request_pin_out), .req_high_in(1'b1),
    .run_in(run), .slow_in(slow), .dir_wr_in(transfer_direction_out), .eot_in(end_of_transfer_input),
    .eot_high_in(1'b0), .ack_n_out(dma_ack_pin_n_in), .rd_out(dma_rd_strobe_in),
    .wr_out(dma_wr_strobe_in), .eot_out(end_of_transfer_input_in));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr_reg(input [7:0] code, input [15:0] data);
    begin
      @(posedge core_clk_in) #1;
      cmd_valid_in = 1;
      cmd_code_in = code;
      cmd_wdata_in = data;
      @(posedge core_clk_in) #1;
      cmd_valid_in = 0;
    end
  endtask
  task rd_reg(input [7:0] code, input [15:0] exp);
    begin
      wr_reg(code, 16'h0000);
      chk({15'h0000, cmd_rvalid_out}, 16'h0001);
      chk(cmd_rdata_out, exp);
    end
  endtask
  // counts access pulses, or low irq cycles when sel is set
  task count(input sel, input integer n);
    begin
      hits = 0;
      repeat (n) begin
        @(posedge core_clk_in) #1;
        hits = hits + (sel ? !irq_pin_out : dma_access_out);
      end
    end
  endtask
  task end_of_test;
    begin
      if (bad_count == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge core_clk_in) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: run too long", $time);
      end_of_test;
    end
  end
  initial begin
    repeat (10) @(posedge core_clk_in);
    #1 reset_in = 0;
    rd_reg(8'h20, 16'h0028);
    rd_reg(8'h21, 16'h0000);
    wr_reg(8'hA0, 16'hFFFF);
    chk({13'h0000, pulldown_internal_out, keep_clock_in_suspend_out,
      overcurrent_analog_select_out}, 16'h0007);
    rd_reg(8'h20, 16'h1DEF);
    wr_reg(8'hA0, 16'h0000);
    wr_reg(8'hA5, 16'hFFFF);
    rd_reg(8'h20, 16'h0008);
    rd_reg(8'h21, 16'h0000);
    chk(dma_request_pin_out, 16'h0001);
    // reserved acknowledge mode must block every access
    wr_reg(8'hA0, 16'h0128);
    wr_reg(8'hA1, 16'h0010);
    run = 1;
    count(0, 20);
    chk(hits, 0);
    wr_reg(8'hA0, 16'h0028);
    for (b = 0; b < 3; b = b + 1) begin
      slow = b[0];
      wr_reg(8'hA1, (b << 5) | 16'h0010 | b[0]);
      chk({14'h0000, burst_length_out}, b);
      count(0, 24);
      chk(hits > 0, 1);
      end_of_transfer_input = 1;
      repeat (2) @(posedge core_clk_in) #1;
      end_of_transfer_input = 0;
      chk(transfer_active_out, 0);
      count(0, 8);
      chk(hits, 0);
    end
    wr_reg(8'hA1, 16'h0016);
    count(0, 16);
    chk(hits, 0);
    byte_count_in = 16'h0040;
    count(0, 16);
    chk(hits > 0, 1);
    count_done_in = 1;
    @(posedge core_clk_in) #1;
    count_done_in = 0;
    chk(transfer_active_out, 0);
    irq_pending_in = 16'h0001;
    host_irq_enable_in = 16'h0001;
    wr_reg(8'hA0, 16'h0028);
    count(1, 6);
    chk(hits, 0);
    wr_reg(8'hA0, 16'h0029);
    count(1, 6);
    chk(hits, 6);
    wr_reg(8'hA0, 16'h002D);
    count(1, 2);
    chk(irq_pin_out, 1);
    host_irq_enable_in = 16'h0000;
    count(1, 2);
    chk(irq_pin_out, 0);
    wr_reg(8'hA0, 16'h002B);
    host_irq_enable_in = 16'h0001;
    count(1, 6);
    chk(hits, 1);
    end_of_test;
  end
endmodule // tb_top
